/* File: rtl/adc_acq_ctrl.sv */
// Acquisition controller for simultaneous delta-sigma inputs
// What this block does
// - One to three simultaneous inputs from channel zero, set by variant.
// - Software gain of 1 or 10 for ten or one volt span.
// - Per-channel excitation source enable, off after reset.
// - Per-channel AC or DC coupling, DC after reset.
// - Samples are always 24 bits wide.
// - One 48 MHz reference paces the sample clock.
// - Sample clock 1 kHz to 216 kHz; scans follow it.
// - Input rate is independent of output rate, no phase lock.
// - First 63 conversions after clock start are discarded.
// - Busy for 8719, 17423 or 34831 periods after rate configuration.
// - Single value: one chosen channel converted and returned at once.
// - Single and all-channel shots end alone; stops are ignored.
// - All-channel shot samples every input together, one gain.
// - After start trigger, all listed channels sample each clock.
// - No reference trigger: all post data until stop or no buffer.
// - Reference trigger: pre data, then post data, stop after count.
// - Post count excludes the sample at the reference trigger.
// - Orderly stop finishes current buffer, then ignores triggers.
// - Abrupt stop halts now, buffer returned partial.
// - Trigger indicator lit while awaiting hardware start trigger, dark idle.
// - Activity indicator blinks while acquiring.
// - Offset binary codes, clipped to all zeros or all ones.
// - Samples pass an 8 kSample FIFO toward the host.
// - Completion event each time a host buffer fills.
// - Out of buffers: overrun event, acquisition stops.
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module adc_acq_ctrl
    import adc_acq_pkg::*;
#(
    parameter int NUM_CH      = 3,
    parameter int BLINK_CYC   = BLINK_CYCLES,
    parameter int SETTLE_SHIFT = 0
) (
    input  wire logic        MCLK_I,
    input  wire logic        RST_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    input  wire adc_in_type  ADC_I,
    output adc_ctl_type      ADC_CTL_O,
    input  wire logic        EXT_TRIG_I,
    output logic             TRIGGER_INDICATOR_O,
    output logic             ACTIVITY_INDICATOR_O
);
    // ==============================
    // State
    localparam logic [2:0] CH_MASK = 3'((1 << NUM_CH) - 1);
    localparam logic [13:0] FULL = 14'(FIFO_DEPTH);
    typedef struct packed {
        acq_state_type st;
        logic          ap_v;
        logic          ap_wr;
        logic [7:0]    ap_a;
        logic [31:0]   hrdata;
        logic [11:0]   chan;
        logic [3:0]    trig;
        logic [31:0]   rate;
        logic [31:0]   post;
        logic [31:0]   buflen;
        logic [31:0]   credits;
        logic [3:0]    ev;
        logic [31:0]   ref_acc;
        logic [31:0]   smp_acc;
        logic          clk_run;
        logic [15:0]   settle;
        logic [5:0]    disc;
        logic          ext_q;
        logic          ref_seen;
        logic          all;
        logic [2:0]    push;
        logic [2:0][23:0] smp;
        logic [1:0]    tag;
        logic          finish;
        logic [31:0]   fill;
        logic [31:0]   pcnt;
        logic [12:0]   wptr;
        logic [12:0]   rptr;
        logic [13:0]   level;
        logic [2:0][23:0] res;
        logic          conv;
        logic          led_trig;
        logic          led_act;
        logic [31:0]   blink;
    } state_type;

    state_type s;
    state_type next_s;
    logic [31:0] mem [FIFO_DEPTH];
    logic        fifo_we;
    logic [31:0] fifo_wd;
    logic        stop_abrupt;

    // Offset binary with range clipping
    function automatic logic [23:0] code(input logic [23:0] d,
                                         input logic o, input logic u);
        if (o) return 24'hffffff;
        if (u) return 24'h000000;
        return {~d[23], d[22:0]};
    endfunction

    // Settling length in sample periods
    function automatic logic [15:0] settle_len(input logic [31:0] r);
        logic [15:0] n;
        if (r <= SETTLE_LO_HZ) n = SETTLE_LO;
        else if (r <= SETTLE_MID_HZ) n = SETTLE_MID;
        else n = SETTLE_HI;
        return n >> SETTLE_SHIFT;
    endfunction

    // ==============================
    // Next state
    always_comb begin
        logic [6:0]  cmd;
        logic [3:0]  clr;
        logic        ref_tick;
        logic        tick;
        logic        rise;
        logic        fall;
        logic        start_hit;
        logic        ref_hit;
        logic        pop;
        logic [1:0]  idx;
        logic [2:0]  list;
        logic [32:0] acc;
        next_s      = s;
        cmd         = 7'h00;
        clr         = 4'h0;
        pop         = 1'b0;
        idx         = 2'h0;
        ref_tick    = 1'b0;
        tick        = 1'b0;
        rise        = 1'b0;
        fall        = 1'b0;
        start_hit   = 1'b0;
        ref_hit     = 1'b0;
        acc         = 33'h0;
        fifo_we     = 1'b0;
        fifo_wd     = 32'h0;
        stop_abrupt = 1'b0;
        next_s.conv = 1'b0;
        list = s.chan[CH_LIST +: 3] & CH_MASK;
        // Register writes in the data phase
        if (s.ap_v && s.ap_wr) begin
            if (s.ap_a == OFS_CTRL) begin
                cmd = HWDATA_I[6:0];
            end else if (s.ap_a == OFS_CHAN) begin
                next_s.chan = HWDATA_I[11:0];
            end else if (s.ap_a == OFS_TRIG) begin
                next_s.trig = HWDATA_I[3:0];
            end else if (s.ap_a == OFS_RATE) begin
                if (HWDATA_I < RATE_MIN) next_s.rate = RATE_MIN;
                else if (HWDATA_I > RATE_MAX) next_s.rate = RATE_MAX;
                else next_s.rate = HWDATA_I;
            end else if (s.ap_a == OFS_POST) begin
                next_s.post = HWDATA_I;
            end else if (s.ap_a == OFS_BUFLEN) begin
                next_s.buflen = HWDATA_I;
            end else if (s.ap_a == OFS_BUFADD) begin
                next_s.credits = s.credits + HWDATA_I;
            end else if (s.ap_a == OFS_STATUS) begin
                clr = HWDATA_I[11:8];
            end
        end
        next_s.ev = s.ev & ~clr;
        // Address phase and read data
        next_s.ap_v  = HSEL_I && HTRANS_I[1] && HREADY_I;
        next_s.ap_wr = HWRITE_I;
        next_s.ap_a  = HADDR_I[7:0];
        next_s.hrdata = 32'h0;
        if (next_s.ap_v && !HWRITE_I) begin
            if (HADDR_I[7:0] == OFS_CHAN) begin
                next_s.hrdata = {20'h0, s.chan};
            end else if (HADDR_I[7:0] == OFS_TRIG) begin
                next_s.hrdata = {28'h0, s.trig};
            end else if (HADDR_I[7:0] == OFS_RATE) begin
                next_s.hrdata = s.rate;
            end else if (HADDR_I[7:0] == OFS_POST) begin
                next_s.hrdata = s.post;
            end else if (HADDR_I[7:0] == OFS_BUFLEN) begin
                next_s.hrdata = s.buflen;
            end else if (HADDR_I[7:0] == OFS_BUFADD) begin
                next_s.hrdata = s.credits;
            end else if (HADDR_I[7:0] == OFS_STATUS) begin
                next_s.hrdata = {2'h0, s.level, 4'h0, s.ev, 3'h0,
                                 s.clk_run, s.settle != 16'h0, s.st};
            end else if (HADDR_I[7:0] == OFS_DATA) begin
                pop = s.level != 14'h0;
                if (pop) next_s.hrdata = mem[s.rptr];
            end else if (HADDR_I[7:0] == OFS_RES0) begin
                next_s.hrdata = {8'h0, s.res[0]};
            end else if (HADDR_I[7:0] == OFS_RES0 + 8'h04) begin
                next_s.hrdata = {8'h0, s.res[1]};
            end else if (HADDR_I[7:0] == OFS_RES0 + 8'h08) begin
                next_s.hrdata = {8'h0, s.res[2]};
            end
        end
        if (pop) next_s.rptr = s.rptr + 13'h1;
        // 48 MHz reference enable from the 250 MHz clock, sample clock from that reference
        acc = {1'b0, s.ref_acc} + 33'(REF_HZ);
        ref_tick = acc >= 33'(CLK_HZ);
        next_s.ref_acc = ref_tick ? 32'(acc - 33'(CLK_HZ)) : acc[31:0];
        tick = 1'b0;
        if (s.clk_run && ref_tick) begin
            acc = {1'b0, s.smp_acc} + {1'b0, s.rate};
            tick = acc >= 33'(REF_HZ);
            next_s.smp_acc = tick ? 32'(acc - 33'(REF_HZ)) : acc[31:0];
        end
        next_s.conv = tick;
        if (tick && s.settle != 16'h0) begin
            next_s.settle = s.settle - 16'h1;
        end
        if (ADC_I.valid && s.clk_run && s.disc != DISCARD_N) begin
            next_s.disc = s.disc + 6'h1;
        end
        // Trigger edges
        next_s.ext_q = EXT_TRIG_I;
        rise = EXT_TRIG_I && !s.ext_q;
        fall = !EXT_TRIG_I && s.ext_q;
        case (s.trig[1:0])
            SRC_SW:   start_hit = cmd[CMD_SWTRIG];
            SRC_RISE: start_hit = rise;
            SRC_FALL: start_hit = fall;
            default:  start_hit = 1'b0;
        endcase
        ref_hit = s.trig[TR_REF_FALL] ? fall : rise;
        // Acquisition sequence
        case (s.st)
            ST_IDLE: begin
                if (cmd[CMD_CONFIG]) begin
                    next_s.clk_run = 1'b1;
                    next_s.smp_acc = 32'h0;
                    next_s.settle  = settle_len(s.rate);
                    next_s.disc    = 6'h0;
                end else if (cmd[CMD_SINGLE] || cmd[CMD_ALL]) begin
                    next_s.st   = ST_SINGLE;
                    next_s.all  = cmd[CMD_ALL];
                    next_s.conv = 1'b1;
                end else if (cmd[CMD_SCAN] && s.clk_run &&
                             s.settle == 16'h0 && s.disc == DISCARD_N) begin
                    next_s.st       = ST_ARM;
                    next_s.fill     = 32'h0;
                    next_s.pcnt     = 32'h0;
                    next_s.ref_seen = 1'b0;
                    next_s.finish   = 1'b0;
                end
            end
            ST_SINGLE: begin
                if (ADC_I.valid) begin
                    for (int i = 0; i < NCH_MAX; i++) begin
                        if (CH_MASK[i] && (s.all ||
                            2'(i) == s.chan[CH_SEL +: 2])) begin
                            next_s.res[i] = code(ADC_I.data[i],
                                ADC_I.over[i], ADC_I.under[i]);
                        end
                    end
                    next_s.ev[EV_SINGLE] = 1'b1;
                    next_s.st = ST_IDLE;
                end
            end
            ST_ARM: begin
                if (start_hit) begin
                    next_s.st = s.trig[TR_REF_EN] ? ST_PRE : ST_POST;
                end
            end
            default: begin
                if (s.st == ST_PRE && ref_hit) next_s.ref_seen = 1'b1;
                if (ADC_I.valid && s.push == 3'h0 && !s.finish) begin
                    next_s.push = list;
                    for (int i = 0; i < NCH_MAX; i++) begin
                        next_s.smp[i] = code(ADC_I.data[i],
                            ADC_I.over[i], ADC_I.under[i]);
                    end
                    next_s.tag = 2'h0;
                    if (s.st == ST_PRE) begin
                        next_s.tag[1] = 1'b1;
                        if (s.ref_seen || ref_hit) begin
                            next_s.tag[0]   = 1'b1;
                            next_s.st       = ST_POST;
                            next_s.ref_seen = 1'b0;
                        end
                    end else if (s.st == ST_POST) begin
                        next_s.pcnt = s.pcnt + 32'h1;
                        if (s.trig[TR_REF_EN] &&
                            s.pcnt + 32'h1 >= s.post) begin
                            next_s.finish = 1'b1;
                        end
                    end
                end
            end
        endcase
        // Push scanned channels into the FIFO in ascending order
        if (s.push != 3'h0) begin
            idx = s.push[0] ? 2'h0 : (s.push[1] ? 2'h1 : 2'h2);
            if (s.level == FULL || s.credits == 32'h0) begin
                next_s.ev[EV_OVERRUN] = 1'b1;
                next_s.st   = ST_IDLE;
                next_s.push = 3'h0;
            end else begin
                fifo_we = 1'b1;
                fifo_wd = {s.tag, 2'h0, idx, 2'h0, s.smp[idx]};
                next_s.wptr = s.wptr + 13'h1;
                next_s.push = s.push & ~(3'h1 << idx);
                if (s.fill + 32'h1 >= s.buflen) begin
                    next_s.fill    = 32'h0;
                    next_s.credits = next_s.credits - 32'h1;
                    next_s.ev[EV_BUFDONE] = 1'b1;
                    if (s.st == ST_DRAIN) next_s.st = ST_IDLE;
                end else begin
                    next_s.fill = s.fill + 32'h1;
                end
            end
        end
        if (fifo_we != pop) begin
            next_s.level = fifo_we ? s.level + 14'h1 : s.level - 14'h1;
        end
        // Post count reached once the last scan is stored
        if (s.finish && s.push == 3'h0 && s.st == ST_POST) begin
            next_s.st = ST_IDLE;
        end
        // Stop requests, ignored by one-shot operations
        if (s.st >= ST_ARM && next_s.st != ST_IDLE) begin
            if (cmd[CMD_ABRUPT]) begin
                stop_abrupt = 1'b1;
                next_s.st   = ST_IDLE;
                next_s.push = 3'h0;
                if (s.fill != 32'h0 || s.push != 3'h0) begin
                    next_s.ev[EV_PARTIAL] = 1'b1;
                end
            end else if (cmd[CMD_ORDERLY]) begin
                if (s.st == ST_ARM ||
                    (s.fill == 32'h0 && s.push == 3'h0)) begin
                    next_s.st = ST_IDLE;
                end else begin
                    next_s.st = ST_DRAIN;
                end
            end
        end
        // Indicators
        next_s.led_trig = next_s.st == ST_ARM &&
                          s.trig[1:0] != SRC_SW;
        if (next_s.st >= ST_ARM) begin
            if (s.blink >= 32'(BLINK_CYC - 1)) begin
                next_s.blink   = 32'h0;
                next_s.led_act = !s.led_act;
            end else begin
                next_s.blink = s.blink + 32'h1;
            end
        end else begin
            next_s.blink   = 32'h0;
            next_s.led_act = 1'b0;
        end
    end

    // ==============================
    // State register
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            s         <= '0;
            s.st      <= ST_IDLE;
            s.chan    <= 12'h000;
            s.rate    <= RATE_RST;
            s.buflen  <= BUFLEN_RST;
        end else begin
            s <= next_s;
        end
    end

    // FIFO storage
    always_ff @(posedge MCLK_I) begin
        if (fifo_we) mem[s.wptr] <= fifo_wd;
    end

    // ==============================
    // Outputs
    assign HRDATA_O             = s.hrdata;
    assign HREADYOUT_O          = 1'b1;
    assign HRESP_O              = 1'b0;
    assign ADC_CTL_O.conv       = s.conv;
    assign ADC_CTL_O.gain10     = s.chan[CH_GAIN];
    assign ADC_CTL_O.ac         = s.chan[CH_AC +: 3] & CH_MASK;
    assign ADC_CTL_O.excite     = s.chan[CH_EXC +: 3] & CH_MASK;
    assign TRIGGER_INDICATOR_O  = s.led_trig;
    assign ACTIVITY_INDICATOR_O = s.led_act;

    // ==============================
    // Checks
    property p_reset_dc;
        @(posedge MCLK_I) RST_I |=> ADC_CTL_O.excite == 3'h0 &&
                                    ADC_CTL_O.ac == 3'h0;
    endproperty
    a_reset_dc: assert property (p_reset_dc)
        else $error("excitation or AC on after reset");

    property p_rate_range;
        @(posedge MCLK_I) disable iff (RST_I)
        s.rate >= RATE_MIN && s.rate <= RATE_MAX;
    endproperty
    a_rate_range: assert property (p_rate_range)
        else $error("sample rate out of range");

    property p_discard;
        @(posedge MCLK_I) disable iff (RST_I)
        fifo_we |-> s.disc == DISCARD_N;
    endproperty
    a_discard: assert property (p_discard)
        else $error("sample stored during discard");

    property p_settle;
        @(posedge MCLK_I) disable iff (RST_I)
        fifo_we |-> s.settle == 16'h0;
    endproperty
    a_settle: assert property (p_settle)
        else $error("sample stored while settling");

    property p_single_conv;
        @(posedge MCLK_I) disable iff (RST_I)
        $rose(s.st == ST_SINGLE) |-> ADC_CTL_O.conv;
    endproperty
    a_single_conv: assert property (p_single_conv)
        else $error("single shot without conversion");

    property p_single_hold;
        @(posedge MCLK_I) disable iff (RST_I)
        (s.st == ST_SINGLE && !ADC_I.valid) |=> s.st == ST_SINGLE;
    endproperty
    a_single_hold: assert property (p_single_hold)
        else $error("single shot left early");

    property p_abrupt;
        @(posedge MCLK_I) disable iff (RST_I)
        stop_abrupt |=> s.st == ST_IDLE && !fifo_we;
    endproperty
    a_abrupt: assert property (p_abrupt)
        else $error("acquisition continued after abrupt stop");

    property p_led_idle;
        @(posedge MCLK_I) disable iff (RST_I)
        s.st != ST_ARM |-> !TRIGGER_INDICATOR_O;
    endproperty
    a_led_idle: assert property (p_led_idle)
        else $error("trigger indicator lit outside arm");

    property p_overrun;
        @(posedge MCLK_I) disable iff (RST_I)
        $rose(s.ev[EV_OVERRUN]) |-> s.st == ST_IDLE ##1 !fifo_we;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("acquisition ran on after overrun");

    c_single: cover property (@(posedge MCLK_I)
        s.st == ST_SINGLE ##1 s.st == ST_IDLE);
    c_post: cover property (@(posedge MCLK_I)
        s.st == ST_PRE ##1 s.st == ST_POST);
    c_overrun: cover property (@(posedge MCLK_I) $rose(s.ev[EV_OVERRUN]));
endmodule // adc_acq_ctrl

/* File: pkg/adc_acq_pkg.sv */
// Constants and types of the acquisition controller
package adc_acq_pkg;
    // ==============================
    // Clocks and rates
    localparam int CLK_HZ        = 250_000_000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int REF_HZ        = 48_000_000;
    localparam logic [31:0] RATE_MIN = 32'h0000_03e8;
    localparam logic [31:0] RATE_MAX = 32'h0003_4bc0;
    localparam logic [31:0] RATE_RST = 32'h0000_03e8;
    localparam int SMP_W         = 24;
    localparam int NCH_MAX       = 3;
    localparam logic [5:0] DISCARD_N = 6'h3f;
    localparam logic [31:0] SETTLE_LO_HZ  = 32'h0000_c350;
    localparam logic [31:0] SETTLE_MID_HZ = 32'h0001_86a0;
    localparam logic [15:0] SETTLE_LO  = 16'h220f;
    localparam logic [15:0] SETTLE_MID = 16'h440f;
    localparam logic [15:0] SETTLE_HI  = 16'h880f;
    localparam int FIFO_DEPTH    = 8192;
    localparam int FIFO_AW       = 13;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_CYCLES  = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
    // ==============================
    // Register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CHAN   = 8'h04;
    localparam logic [7:0] OFS_TRIG   = 8'h08;
    localparam logic [7:0] OFS_RATE   = 8'h0c;
    localparam logic [7:0] OFS_POST   = 8'h10;
    localparam logic [7:0] OFS_BUFLEN = 8'h14;
    localparam logic [7:0] OFS_BUFADD = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_DATA   = 8'h20;
    localparam logic [7:0] OFS_RES0   = 8'h24;
    // ==============================
    // Field positions and reset values
    localparam int CMD_SINGLE = 0;
    localparam int CMD_ALL    = 1;
    localparam int CMD_SCAN   = 2;
    localparam int CMD_CONFIG = 3;
    localparam int CMD_SWTRIG = 4;
    localparam int CMD_ORDERLY = 5;
    localparam int CMD_ABRUPT = 6;
    localparam int CH_GAIN = 0;
    localparam int CH_AC   = 1;
    localparam int CH_EXC  = 4;
    localparam int CH_LIST = 7;
    localparam int CH_SEL  = 10;
    localparam int TR_REF_EN   = 2;
    localparam int TR_REF_FALL = 3;
    localparam logic [1:0] SRC_SW   = 2'h0;
    localparam logic [1:0] SRC_RISE = 2'h1;
    localparam logic [1:0] SRC_FALL = 2'h2;
    localparam int EV_BUFDONE = 0;
    localparam int EV_OVERRUN = 1;
    localparam int EV_PARTIAL = 2;
    localparam int EV_SINGLE  = 3;
    localparam logic [31:0] BUFLEN_RST = 32'h0000_0100;
    // ==============================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE, ST_SINGLE, ST_ARM, ST_PRE, ST_POST, ST_DRAIN
    } acq_state_type;
    typedef struct packed {
        logic                       valid;
        logic [NCH_MAX-1:0]         over;
        logic [NCH_MAX-1:0]         under;
        logic [NCH_MAX-1:0][SMP_W-1:0] data;
    } adc_in_type;
    typedef struct packed {
        logic               conv;
        logic               gain10;
        logic [NCH_MAX-1:0] ac;
        logic [NCH_MAX-1:0] excite;
    } adc_ctl_type;
endpackage

/* File: test/adc_conv_model.sv */
// Converter model answering conversion pulses
`timescale 1ns/1ps
module adc_conv_model
    import adc_acq_pkg::*;
(
    input  wire logic        clk_i,
    input  wire adc_ctl_type ctl_i,
    input  wire logic [23:0] level_i,
    input  wire logic        clip_i,
    output adc_in_type       adc_o
);
    logic [3:0] dly = 4'h0;
    // =========================================
    // Result a few cycles after each pulse, noise between
    initial begin
        adc_o = '0;
        forever @(posedge clk_i) begin
            if (ctl_i.conv) dly <= 4'h5;
            else if (dly != 4'h0) dly <= dly - 4'h1;
            adc_o.valid <= (dly == 4'h1);
            adc_o.data  <= (dly == 4'h1) ? {3{level_i}} : ~adc_o.data;
            adc_o.over  <= {3{clip_i}};
            adc_o.under <= 3'h0;
        end
    end
endmodule // adc_conv_model

/* File: test/adc_acquisition_control_test.sv */
// Self-checking bench of the acquisition controller
`timescale 1ns/1ps
module adc_acquisition_control_test
    import adc_acq_pkg::*;
;
    logic        clk = 0, rst = 1, wr = 0, clip = 0, rdy, resp, tind, aind;
    logic        trg = 0, a0;
    logic [31:0] q [$];
    logic [1:0]  trans = 2'h0;
    logic [31:0] addr = 0, wdata = 0, rdata, s, seed = 32'h52;
    logic [23:0] level = 24'h0, expv;
    adc_in_type  adc;
    adc_ctl_type ctl;
    int          errors = 0, checks_done = 0, i, n;
    // Clock and design under test
    always #2 clk = ~clk;
    adc_acq_ctrl #(.BLINK_CYC(8), .SETTLE_SHIFT(10)) i_adc_acq_ctrl (
        .MCLK_I(clk), .RST_I(rst), .HSEL_I(1'b1), .HADDR_I(addr),
        .HTRANS_I(trans), .HWRITE_I(wr), .HSIZE_I(3'h2), .HWDATA_I(wdata),
        .HREADY_I(rdy), .HRDATA_O(rdata), .HREADYOUT_O(rdy),
        .HRESP_O(resp), .ADC_I(adc), .ADC_CTL_O(ctl), .EXT_TRIG_I(trg),
        .TRIGGER_INDICATOR_O(tind), .ACTIVITY_INDICATOR_O(aind));
    adc_conv_model i_adc_conv_model (
        .clk_i(clk), .ctl_i(ctl), .level_i(level), .clip_i(clip),
        .adc_o(adc));
    // =========================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13; x ^= x >> 17; return x ^ (x << 5);
    endfunction
    task automatic check(input string nm, input logic [31:0] a, b);
        checks_done++;
        if (a !== b) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, b, a);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk); addr <= {24'h0, a}; trans <= 2'h2; wr <= w;
        do @(posedge clk); while (rdy !== 1'b1);
        trans <= 2'h0; wdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        r = rdata;
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog
    initial begin
        #360000;
        errors++;
        conclude();
    end
    // =========================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        ahb(0, OFS_CHAN, 0, s); check("chan", s, 0);
        ahb(0, OFS_BUFLEN, 0, s); check("buflen", s, BUFLEN_RST);
        ahb(0, 8'h30, 0, s); check("unmapped", s, 0);
        ahb(1, OFS_RATE, 5, s); ahb(0, OFS_RATE, 0, s);
        check("rate clamp", s, RATE_MIN);
        ahb(1, OFS_CHAN, 32'h7f, s); // AC with excitation
        @(posedge clk);
        check("ctl", {ctl.gain10, ctl.ac, ctl.excite}, 7'h7f);
        for (i = 0; i < 4; i++) begin
            seed = xs(seed);
            level <= seed[23:0]; clip <= (i == 3);
            expv = (i == 3) ? 24'hffffff : {~seed[23], seed[22:0]};
            ahb(1, OFS_CHAN, (i % 3) << 10, s);
            ahb(1, OFS_CTRL, (i == 3) ? 2 : 1, s);
            ahb(1, OFS_CTRL, 32'h40, s); // Stop aimed at a shot
            s = 0;
            for (n = 0; n < 50 && s[11] !== 1'b1; n++) begin
                ahb(0, OFS_STATUS, 0, s);
            end
            check("shot done", s[11], 1);
            for (n = 0; n < 3; n++) if (i == 3 || n == i) begin
                ahb(0, OFS_RES0 + 8'(4 * n), 0, s);
                check("result", s[23:0], expv);
            end
            ahb(1, OFS_STATUS, 32'h800, s);
        end
        check("indicators idle", {tind, aind}, 0);
        ahb(1, OFS_RATE, RATE_MAX, s);
        ahb(1, OFS_CTRL, 8, s);
        ahb(1, OFS_CTRL, 4, s);
        ahb(0, OFS_STATUS, 0, s);
        check("scan refused", s[4:0], 5'h18);
        // Continuous scan, rising external start, one buffer of three
        seed = xs(seed);
        level <= seed[23:0];
        clip <= 0;
        ahb(1, OFS_TRIG, 1, s);
        ahb(1, OFS_CHAN, 32'h380, s); // Ascending list 0 to 2
        ahb(1, OFS_BUFLEN, 3, s);
        ahb(1, OFS_BUFADD, 1, s);
        s = 0;
        for (n = 0; n < 85 && s[2:0] !== 3'h2; n++) begin
            repeat (1000) @(posedge clk);
            ahb(1, OFS_CTRL, 4, s);
            ahb(0, OFS_STATUS, 0, s);
        end
        repeat (2) @(posedge clk);
        check("trig lit", tind, 1);
        a0 = aind;
        repeat (8) @(posedge clk);
        check("blink", aind, !a0);
        trg <= 1;
        for (n = 0; n < 3; n++) begin
            q.push_back({4'h0, n[1:0], 2'h0, ~level[23], level[22:0]});
        end
        s = 0;
        for (n = 0; n < 1000 && s[9] !== 1'b1; n++) begin
            ahb(0, OFS_STATUS, 0, s);
        end
        check("stopped", s[11:0], 12'h310);
        check("level", s[29:16], 3);
        while (q.size() > 0) begin
            ahb(0, OFS_DATA, 0, s);
            check("data", s, q.pop_front());
        end
        ahb(0, OFS_DATA, 0, s);
        check("empty", s, 0);
        ahb(1, OFS_CTRL, 4, s);
        ahb(1, OFS_CTRL, 32'h20, s);
        ahb(0, OFS_STATUS, 0, s);
        check("orderly stop", s[2:0], 0);
        conclude();
    end
endmodule // adc_acquisition_control_test
